// [hdl/ptu_mode_io.sv]
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Mode registers reset to c0.
// - Mode bits 7,6 read one, software writes zero.
// - Channel 0 B pairing silences register D.
// - Channel 0 A pairing only drives pair_a_buffer_bit.
// - Channels 1,2 mode bits 5,4 read zero.
// - Mode field decodes normal, PWM, phase counting.
// - Four pin function registers reset to zero.
// - Buffer registers ignore their pin function.
// - Initial level driven while counter halted.
// - PWM mode 2 sets level at clear.
// - Codes 0xxx are compare output actions.
// - Codes 10xx capture on chosen pin edges.
// - Low register holds D high, C low.
module ptu_mode_io
    import ptu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [3:0]  compare_match,
    input  wire logic [2:0]  counter_clear,
    input  wire logic [3:0]  capture_pin_in,
    output logic [3:0]       compare_pin_out,
    output logic [3:0]       compare_pin_oe,
    output logic [3:0]       capture_event,
    output logic [2:0]       counter_start_bit,
    output logic [2:0]       pwm2_active,
    output logic [2:0]       phase_count_active,
    output logic             pair_a_buffer_bit,
    output logic             pair_b_buffer_bit
);

    // Function slots 0..3 are register B of channels 0,1,2 and register D.
    localparam int unsigned NSLOT = 4;

    logic [7:0]  mode_q [PTU_NUM_CH];  // Writable mode bits; fixed bits added on read.
    logic [7:0]  io0h_q;               // Channel 0 high pin function register.
    logic [7:0]  io1_q;                // Channel 1 pin function register.
    logic [7:0]  io2_q;                // Channel 2 pin function register.
    logic [7:0]  io0l_q;               // Channel 0 low pin function register.
    logic [2:0]  start_q;              // Counter start bits, one per channel.
    ptu_opmode_t opmode [PTU_NUM_CH];  // Decoded mode per channel.

    logic        aw_held_q;            // Write address accepted and waiting.
    logic [5:0]  aw_addr_q;            // Captured write address.
    logic        w_held_q;             // Write data accepted and waiting.
    logic [31:0] w_data_q;             // Captured write data.
    logic [3:0]  w_strb_q;             // Captured write strobes.
    logic        bvalid_q;             // Write response pending.
    logic [1:0]  bresp_q;              // Write response code.
    logic        rvalid_q;             // Read response pending.
    logic [31:0] rdata_q;              // Read data.
    logic [1:0]  rresp_q;              // Read response code.
    logic        wr_fire;              // Both halves of a write are in hand.
    logic        wr_hit;               // Write address is mapped.
    logic [31:0] rd_word;              // Read mux output.
    logic        rd_hit;               // Read address is mapped.

    logic [3:0]  slot_func  [NSLOT];   // Pin function code per slot.
    logic [NSLOT-1:0] slot_buf;        // Slot register is used as a buffer.
    logic [NSLOT-1:0] slot_run;        // Owning channel's counter runs.
    logic [NSLOT-1:0] slot_clr;        // Owning channel's counter clear.
    logic [NSLOT-1:0] slot_pwm2;       // Owning channel is in PWM mode 2.

    // The slave takes address and data in either order and holds each
    // until the other arrives, so a single write is in flight at a time.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;

    // Write address capture.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 6'h00;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    // Write data capture.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Address decode for writes; the status word is read only.
    always_comb begin
        case (aw_addr_q)
            PTU_OFF_CH0_MODE, PTU_OFF_CH1_MODE, PTU_OFF_CH2_MODE,
            PTU_OFF_CH0_IO_HI, PTU_OFF_CH1_IO, PTU_OFF_CH2_IO,
            PTU_OFF_CH0_IO_LO, PTU_OFF_START: wr_hit = 1'b1;
            default:                          wr_hit = 1'b0;
        endcase
    end

    // Write response one cycle after both halves are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= PTU_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? PTU_RESP_OKAY : PTU_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Mode registers; only lane 0 carries data. Unwritable bits are masked
    // off so a read always reflects the fixed values, not stray writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < PTU_NUM_CH; i++) begin
                mode_q[i] <= PTU_MODE_RESET & PTU_MODE_WMASK_CH0;
            end
        end else if (clk_en && wr_fire && w_strb_q[0]) begin
            if (aw_addr_q == PTU_OFF_CH0_MODE) begin
                mode_q[0] <= w_data_q[7:0] & PTU_MODE_WMASK_CH0;
            end
            if (aw_addr_q == PTU_OFF_CH1_MODE) begin
                mode_q[1] <= w_data_q[7:0] & PTU_MODE_WMASK_CHN;
            end
            if (aw_addr_q == PTU_OFF_CH2_MODE) begin
                mode_q[2] <= w_data_q[7:0] & PTU_MODE_WMASK_CHN;
            end
        end
    end

    // Pin function registers, all cleared to output disabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io0h_q <= PTU_IO_RESET;
            io1_q  <= PTU_IO_RESET;
            io2_q  <= PTU_IO_RESET;
            io0l_q <= PTU_IO_RESET;
        end else if (clk_en && wr_fire && w_strb_q[0]) begin
            if (aw_addr_q == PTU_OFF_CH0_IO_HI) begin
                io0h_q <= w_data_q[7:0];
            end
            if (aw_addr_q == PTU_OFF_CH1_IO) begin
                io1_q <= w_data_q[7:0];
            end
            if (aw_addr_q == PTU_OFF_CH2_IO) begin
                io2_q <= w_data_q[7:0];
            end
            if (aw_addr_q == PTU_OFF_CH0_IO_LO) begin
                io0l_q <= w_data_q[7:0];
            end
        end
    end

    // Counter start bits; they gate initial-level output while clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 3'h0;
        end else if (clk_en && wr_fire && w_strb_q[0] && aw_addr_q == PTU_OFF_START) begin
            start_q <= w_data_q[2:0];
        end
    end

    // Mode decode, one channel at a time and independently.
    generate
        for (genvar c = 0; c < PTU_NUM_CH; c++) begin : g_mode
            always_comb begin
                case (mode_q[c][2:0])
                    3'b000:  opmode[c] = PTU_OPM_NORMAL;
                    3'b001:  opmode[c] = PTU_OPM_RESERVED;
                    3'b010:  opmode[c] = PTU_OPM_PWM1;
                    3'b011:  opmode[c] = PTU_OPM_PWM2;
                    3'b100:  opmode[c] = PTU_OPM_PHASE1;
                    3'b101:  opmode[c] = PTU_OPM_PHASE2;
                    3'b110:  opmode[c] = PTU_OPM_PHASE3;
                    default: opmode[c] = PTU_OPM_PHASE4;
                endcase
            end
            assign pwm2_active[c]        = (opmode[c] == PTU_OPM_PWM2);
            assign phase_count_active[c] = mode_q[c][2];
        end
    endgenerate

    assign pair_a_buffer_bit = mode_q[0][PTU_MODE_PAIR_A];
    assign pair_b_buffer_bit = mode_q[0][PTU_MODE_PAIR_B];
    assign counter_start_bit = start_q;

    // Slot mapping: B of each channel from bits 7..4, D from channel 0 low.
    assign slot_func[0] = io0h_q[7:4];
    assign slot_func[1] = io1_q[7:4];
    assign slot_func[2] = io2_q[7:4];
    assign slot_func[3] = io0l_q[7:4];
    assign slot_buf     = {pair_b_buffer_bit, 3'b000};
    assign slot_run     = {start_q[0], start_q};
    assign slot_clr     = {counter_clear[0], counter_clear};
    assign slot_pwm2    = {pwm2_active[0], pwm2_active};

    // One pin function unit per general register slot.
    generate
        for (genvar s = 0; s < NSLOT; s++) begin : g_slot
            ptu_pin_func u_func (
                .aclk          (aclk),
                .aresetn       (aresetn),
                .clk_en        (clk_en),
                .func          (slot_func[s]),
                .as_buffer     (slot_buf[s]),
                .running       (slot_run[s]),
                .compare_match (compare_match[s]),
                .counter_clear (slot_clr[s]),
                .pwm2          (slot_pwm2[s]),
                .pin_in        (capture_pin_in[s]),
                .pin_out       (compare_pin_out[s]),
                .pin_oe        (compare_pin_oe[s]),
                .capture       (capture_event[s])
            );
        end
    endgenerate

    // Read mux: mode reads add the fixed one bits.
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            PTU_OFF_CH0_MODE:  rd_word[7:0] = mode_q[0] | PTU_MODE_FIXED_ONE;
            PTU_OFF_CH1_MODE:  rd_word[7:0] = mode_q[1] | PTU_MODE_FIXED_ONE;
            PTU_OFF_CH2_MODE:  rd_word[7:0] = mode_q[2] | PTU_MODE_FIXED_ONE;
            PTU_OFF_CH0_IO_HI: rd_word[7:0] = io0h_q;
            PTU_OFF_CH1_IO:    rd_word[7:0] = io1_q;
            PTU_OFF_CH2_IO:    rd_word[7:0] = io2_q;
            PTU_OFF_CH0_IO_LO: rd_word[7:0] = io0l_q;
            PTU_OFF_START:     rd_word[2:0] = start_q;
            PTU_OFF_STATUS:    rd_word[7:0] = {compare_pin_oe, compare_pin_out};
            default:           rd_hit = 1'b0;
        endcase
    end

    // Read response one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= PTU_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_hit ? PTU_RESP_OKAY : PTU_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Channel 1 mode reads show bits 7,6 as one and bits 5,4 as zero.
    property p_mode_fixed;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && clk_en && s_axi_araddr == PTU_OFF_CH1_MODE)
            |=> (rdata_q[7:4] == 4'hc);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed)
        else $error("Channel 1 mode read shows wrong fixed bits.");

    // Channel 0 mode reads back c0 after reset until written.
    property p_mode_reset;
        @(posedge aclk)
        !aresetn |=> (mode_q[0] | PTU_MODE_FIXED_ONE) == PTU_MODE_RESET;
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("Mode register reset value wrong.");

    // Buffered register D never captures, and its registered enable drops one edge later.
    property p_d_silent;
        @(posedge aclk) disable iff (!aresetn)
        (pair_b_buffer_bit && clk_en) |-> !capture_event[3] ##1 !compare_pin_oe[3];
    endproperty
    a_d_silent: assert property (p_d_silent)
        else $error("Buffered register D produced an event.");

    // A halted enabled output settles to the initial level.
    property p_init_level;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && !start_q[1] && io1_q[7:4] == 4'h5) |=> compare_pin_out[1];
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("Initial output level not driven while halted.");

    // Disabled codes never enable the pin.
    property p_off_codes;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && (io2_q[7:4] == PTU_IO_OFF0 || io2_q[7:4] == PTU_IO_OFF1))
            |=> !compare_pin_oe[2];
    endproperty
    a_off_codes: assert property (p_off_codes)
        else $error("Disabled function code drove the pin.");

    // Every write is answered one cycle after both halves are held.
    property p_wr_answer;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && clk_en) |=> bvalid_q;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("Write response missing.");

    // Capture mode never enables the output.
    property p_cap_no_oe;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && io0h_q[7]) |=> !compare_pin_oe[0];
    endproperty
    a_cap_no_oe: assert property (p_cap_no_oe)
        else $error("Capture function enabled the output.");

    // PWM mode 2 flag follows the mode field decode.
    property p_pwm2;
        @(posedge aclk) disable iff (!aresetn)
        pwm2_active[2] |-> (mode_q[2][2:0] == 3'b011);
    endproperty
    a_pwm2: assert property (p_pwm2)
        else $error("PWM mode 2 decode wrong.");

endmodule // ptu_mode_io

// [hdl/ptu_pin_func.sv]
`timescale 1ns/1ps
// One general register's pin function: compare output or input capture.
module ptu_pin_func
    import ptu_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clk_en,
    input  wire logic [3:0] func,
    input  wire logic       as_buffer,
    input  wire logic       running,
    input  wire logic       compare_match,
    input  wire logic       counter_clear,
    input  wire logic       pwm2,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            capture
);

    logic       init_level;   // Level taken while the counter is halted.
    logic       out_en;       // Compare codes other than the two off codes.
    logic       cap_mode;     // Codes 1000 to 1011.
    logic       sync1_q;      // First synchroniser stage, read only by sync2_q.
    logic       sync2_q;      // Second stage.
    logic       sync3_q;      // Third stage.
    logic       rise;         // Second stage high while third stage still low.
    logic       fall;         // Second stage low while third stage still high.

    assign init_level = func[2];
    assign out_en     = !func[3] && (func[1:0] != 2'b00) && !as_buffer;
    assign cap_mode   = (func[3:2] == 2'b10) && !as_buffer;

    // Three-stage synchroniser for the capture pin.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign rise = sync2_q && !sync3_q;
    assign fall = !sync2_q && sync3_q;

    // Capture strobe: rising, falling or both edges by the low code bits.
    always_comb begin
        capture = 1'b0;
        if (cap_mode && clk_en) begin
            case (func[1:0])
                2'b00:   capture = rise;
                2'b01:   capture = fall;
                default: capture = rise || fall;
            endcase
        end
    end

    // Output level: initial level while halted, match action while running.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 1'b0;
        end else if (clk_en) begin
            if (!out_en) begin
                pin_out <= pin_out;
            end else if (!running) begin
                pin_out <= init_level;
            end else if (pwm2 && counter_clear) begin
                pin_out <= init_level;
            end else if (compare_match) begin
                case (func[1:0])
                    2'b01:   pin_out <= 1'b0;
                    2'b10:   pin_out <= 1'b1;
                    default: pin_out <= !pin_out;
                endcase
            end
        end
    end

    // Pin enable follows the registered function setting.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe <= 1'b0;
        end else if (clk_en) begin
            pin_oe <= out_en;
        end
    end

endmodule // ptu_pin_func

// [hdl/ptu_pkg.sv]
package ptu_pkg;

    // Number of timer channels.
    localparam int unsigned PTU_NUM_CH = 3;

    // Byte addresses of the registers on the AXI4-Lite slave.
    localparam logic [5:0] PTU_OFF_CH0_MODE   = 6'h00;
    localparam logic [5:0] PTU_OFF_CH1_MODE   = 6'h04;
    localparam logic [5:0] PTU_OFF_CH2_MODE   = 6'h08;
    localparam logic [5:0] PTU_OFF_CH0_IO_HI  = 6'h0c;
    localparam logic [5:0] PTU_OFF_CH1_IO     = 6'h10;
    localparam logic [5:0] PTU_OFF_CH2_IO     = 6'h14;
    localparam logic [5:0] PTU_OFF_CH0_IO_LO  = 6'h18;
    localparam logic [5:0] PTU_OFF_START      = 6'h1c;
    localparam logic [5:0] PTU_OFF_STATUS     = 6'h20;

    // Reset values.
    localparam logic [7:0] PTU_MODE_RESET     = 8'hc0;
    localparam logic [7:0] PTU_IO_RESET       = 8'h00;

    // Mode register layout.
    localparam int unsigned PTU_MODE_PAIR_B   = 5;
    localparam int unsigned PTU_MODE_PAIR_A   = 4;
    localparam logic [7:0] PTU_MODE_FIXED_ONE = 8'hc0;
    localparam logic [7:0] PTU_MODE_WMASK_CH0 = 8'h3f;
    localparam logic [7:0] PTU_MODE_WMASK_CHN = 8'h0f;

    // Decoded operating mode, one-hot codes.
    typedef enum logic [7:0] {
        PTU_OPM_NORMAL   = 8'h01,
        PTU_OPM_RESERVED = 8'h02,
        PTU_OPM_PWM1     = 8'h04,
        PTU_OPM_PWM2     = 8'h08,
        PTU_OPM_PHASE1   = 8'h10,
        PTU_OPM_PHASE2   = 8'h20,
        PTU_OPM_PHASE3   = 8'h40,
        PTU_OPM_PHASE4   = 8'h80
    } ptu_opmode_t;

    // Pin function codes, 4 bits.
    localparam logic [3:0] PTU_IO_OFF0        = 4'h0;
    localparam logic [3:0] PTU_IO_OFF1        = 4'h4;
    localparam logic [3:0] PTU_IO_CAP_RISE    = 4'h8;
    localparam logic [3:0] PTU_IO_CAP_FALL    = 4'h9;

    // AXI responses.
    localparam logic [1:0] PTU_RESP_OKAY      = 2'h0;
    localparam logic [1:0] PTU_RESP_SLVERR    = 2'h2;

endpackage

// [verif/tb_ptu_mode_io.sv]
`timescale 1ns/1ps
module tb_ptu_mode_io
    import ptu_pkg::*;
;
    localparam logic [1:0] OK = PTU_RESP_OKAY; // Short alias for the good response.
    logic        aclk, aresetn, ce, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
    logic        awready, wready, arready, pab, pbb;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  match, pin_in, pin_out, pin_oe, cap;
    logic [2:0]  clr, start, pwm2, phase;
    int          fail_count, total_checks, cyc, i, n; // Bench bookkeeping.
    int          cnt [4];                              // Capture pulses seen per slot.
    logic [5:0]  offs [7] = '{PTU_OFF_CH0_MODE, PTU_OFF_CH1_MODE, PTU_OFF_CH2_MODE,
        PTU_OFF_CH0_IO_HI, PTU_OFF_CH1_IO, PTU_OFF_CH2_IO, PTU_OFF_CH0_IO_LO};
    ptu_mode_io DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .compare_match(match), .counter_clear(clr), .capture_pin_in(pin_in),
        .compare_pin_out(pin_out), .compare_pin_oe(pin_oe), .capture_event(cap),
        .counter_start_bit(start), .pwm2_active(pwm2), .phase_count_active(phase),
        .pair_a_buffer_bit(pab), .pair_b_buffer_bit(pbb));
    // Free-running 25 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Counts capture pulses and cuts a hang short after a fixed ceiling.
    always @(posedge aclk) begin
        cyc++;
        for (int k = 0; k < 4; k++) if (cap[k] === 1'b1) cnt[k]++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    // One comparison; case inequality so that an unknown never matches.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write one register; both halves are offered together and each is released when taken.
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = (awvalid && awready) === 1'b1; tw = (wvalid && wready) === 1'b1;
            tb = bvalid === 1'b1; r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    // Read one register; data is only compared when a good response is expected.
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ta, tv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = (arvalid && arready) === 1'b1; tv = rvalid === 1'b1; d = rdata; r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tv);
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, r});
        if (er === OK) chk("rdata", {24'h0, e}, d);
    endtask
    // Let c edges pass, then stop mid-cycle where outputs have settled.
    task automatic settle(input int c);
        repeat (c) @(posedge aclk);
        @(negedge aclk);
    endtask
    // One-cycle pulses on the compare-match and counter-clear inputs.
    task automatic pulse(input logic [3:0] m, input logic [2:0] c);
        @(posedge aclk);
        match <= m; clr <= c;
        @(posedge aclk);
        match <= 4'h0; clr <= 3'h0;
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 6'h00; araddr = 6'h00; wdata = 32'h0; match = 4'h0;
        clr = 3'h0; pin_in = 4'h0; ce = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++) rd(offs[i], (i < 3) ? 8'hc0 : 8'h00, OK);
        settle(1);
        chk("oe_reset", 32'h0, {28'h0, pin_oe});
        $display("Test reset values done");
        wr(PTU_OFF_CH0_MODE, 8'h13, OK);
        wr(PTU_OFF_CH1_MODE, 8'h37, OK);
        rd(PTU_OFF_CH0_MODE, 8'hd3, OK);
        rd(PTU_OFF_CH1_MODE, 8'hc7, OK);
        rd(PTU_OFF_CH2_MODE, 8'hc0, OK);
        settle(1);
        chk("pair_a", 32'h1, {31'h0, pab});
        chk("phase1", 32'h1, {31'h0, phase[1]});
        wr(6'h24, 8'h55, PTU_RESP_SLVERR);
        rd(6'h24, 8'h00, PTU_RESP_SLVERR);
        $display("Test mode fields done");
        for (i = 0; i < 8; i++) begin
            wr(PTU_OFF_CH2_MODE, i[7:0], OK);
            rd(PTU_OFF_CH2_MODE, 8'hc0 | i[7:0], OK);
            chk("pwm2", {31'h0, i == 3}, {31'h0, pwm2[2]});
            chk("phase", {31'h0, i >= 4}, {31'h0, phase[2]});
        end
        $display("Test mode decode done");
        wr(PTU_OFF_CH1_MODE, 8'h00, OK);
        for (i = 1; i < 8; i++) begin
            wr(PTU_OFF_START, 8'h00, OK);
            wr(PTU_OFF_CH1_IO, {i[3:0], 4'h0}, OK);
            settle(1);
            chk("oe1", {31'h0, i != 4}, {31'h0, pin_oe[1]});
            if (i != 4) begin
                chk("init1", {31'h0, i[2]}, {31'h0, pin_out[1]});
                wr(PTU_OFF_START, 8'h02, OK);
                pulse(4'b0010, 3'h0);
                settle(1);
                chk("match1", {31'h0, (i[1:0] == 2) || (i[1:0] == 3 && !i[2])},
                    {31'h0, pin_out[1]});
            end
        end
        chk("start", 32'h2, {29'h0, start});
        wr(PTU_OFF_START, 8'h00, OK);
        wr(PTU_OFF_CH1_MODE, 8'h03, OK);
        wr(PTU_OFF_CH1_IO, 8'h50, OK);
        wr(PTU_OFF_START, 8'h02, OK);
        pulse(4'b0010, 3'h0);
        settle(1);
        chk("pwm2_match", 32'h0, {31'h0, pin_out[1]});
        pulse(4'h0, 3'b010);
        settle(1);
        chk("pwm2_clear", 32'h1, {31'h0, pin_out[1]});
        $display("Test compare output done");
        // Codes 8, 9 and a: rising, falling, both edges on the channel 2 pin.
        for (i = 0; i < 3; i++) begin
            wr(PTU_OFF_CH2_IO, 8'h80 + 8'(i << 4), OK);
            n = cnt[2];
            pin_in <= 4'b0100;
            settle(8);
            chk("cap_rise", {31'h0, i != 1}, 32'(cnt[2] - n));
            n = cnt[2];
            pin_in <= 4'b0000;
            settle(8);
            chk("cap_fall", {31'h0, i != 0}, 32'(cnt[2] - n));
        end
        $display("Test input capture done");
        wr(PTU_OFF_START, 8'h00, OK);
        wr(PTU_OFF_CH0_MODE, 8'h00, OK);
        wr(PTU_OFF_CH0_IO_LO, 8'h50, OK);
        settle(1);
        chk("d_oe", 32'h1, {31'h0, pin_oe[3]});
        chk("d_init", 32'h1, {31'h0, pin_out[3]});
        wr(PTU_OFF_CH0_MODE, 8'h20, OK);
        settle(1);
        chk("pair_b", 32'h1, {31'h0, pbb});
        chk("d_oe_buf", 32'h0, {31'h0, pin_oe[3]});
        wr(PTU_OFF_CH0_IO_LO, 8'h80, OK);
        n = cnt[3];
        pin_in <= 4'b1000;
        settle(8);
        chk("d_cap_buf", 32'h0, 32'(cnt[3] - n));
        $display("Test buffer pairing done");
        wr(PTU_OFF_CH0_IO_HI, 8'h70, OK);
        rd(PTU_OFF_STATUS, 8'h3b, OK);
        wr(PTU_OFF_CH0_IO_HI, 8'h90, OK);
        rd(PTU_OFF_STATUS, 8'h2b, OK);
        // With the clock enable low a pin edge must neither move nor fire.
        ce <= 1'b0;
        n = cnt[2];
        pin_in <= 4'b1100;
        settle(8);
        chk("cap_frozen", 32'h0, 32'(cnt[2] - n));
        @(posedge aclk);
        ce <= 1'b1;
        settle(8);
        chk("cap_thawed", 32'h1, 32'(cnt[2] - n));
        $display("Test status and clock enable done");
        test_done();
    end
endmodule // tb_ptu_mode_io
